// [pkg/i2cbp_pkg.sv]
package i2cbp_pkg;
  localparam int          ADDR_W        = 16;
  localparam logic [15:0] CTL_OFS       = 16'hffc0;
  localparam logic [15:0] TX_OFS        = 16'hffc1;
  localparam logic [15:0] RX_OFS        = 16'hffc2;
  localparam logic [15:0] SEL_OFS       = 16'hffc3;
  localparam logic [7:0]  TX_RST        = 8'h00;
  localparam logic [7:0]  RX_RST        = 8'h00;
  localparam logic [7:0]  SEL_RST       = 8'h00;
  localparam int          CTL_RXF_BIT   = 7;
  localparam int          CTL_ERR_BIT   = 5;
  localparam int          CTL_TXE_BIT   = 3;
  localparam int          CTL_STPRD_BIT = 1;
  localparam int          CTL_STPWR_BIT = 0;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          QUARTER_NS    = 2500;
  localparam int          QUARTER_CYC   = QUARTER_NS / CLK_PERIOD_NS;
  localparam int          DIV_W         = 6;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BITS, ST_HOLD, ST_STOP} i2cbp_state_t;
  typedef enum logic [1:0] {K_ADDR_WR, K_TX, K_ADDR_RD, K_RX} i2cbp_kind_t;
endpackage

// [core/i2cbp_sync.sv]
// two-stage synchroniser for the bus lines
module i2cbp_sync (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// [core/i2cbp_master.sv]
// Summary of operation
// - bit 0 of target_select picks direction: one reads, zero writes.
// - the seven-bit value only selects the slave, never an address inside it.
// - every received byte overwrites rx_byte, which holds the latest byte.
// - tx_byte is write-only and holds the next address or data byte to send.
// - rx_full_flag sets on new byte, clears on rx_byte read, not on interrupt acknowledge.
module i2cbp_master (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out
);
  i2cbp_pkg::i2cbp_state_t state_q, state_d;
  i2cbp_pkg::i2cbp_kind_t  kind_q, kind_d;
  logic [i2cbp_pkg::DIV_W-1:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] sel_q, sel_d;
  logic [7:0] rdata_q, rdata_d;
  logic       tx_pend_q, tx_pend_d;
  logic       rx_full_q, rx_full_d;
  logic       err_q, err_d;
  logic       stop_wr_q, stop_wr_d;
  logic       stop_rd_q, stop_rd_d;
  logic       ack_q, ack_d;
  logic       scl_oe_q, scl_oe_d;
  logic       sda_oe_q, sda_oe_d;
  logic       low_q;
  logic [1:0] line_s;
  logic       scl_s, sda_s, tick, step, sending, rx_set, tx_wr;

  i2cbp_sync u_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  ({scl_in, sda_in}),
    .sync_out  (line_s)
  );

  assign scl_s   = line_s[1];
  assign sda_s   = line_s[0];
  assign tick    = (div_q == i2cbp_pkg::DIV_W'(i2cbp_pkg::QUARTER_CYC - 1));
  // a slave holding the clock low stretches the high phase
  assign step    = tick && !(ph_q == 2'h2 && !scl_s);
  assign sending = (kind_q != i2cbp_pkg::K_RX);
  // a tx_byte write in the cycle that consumes the pending byte stays pending
  assign tx_wr   = wr_en_in && (addr_in == i2cbp_pkg::TX_OFS);
  assign rx_set  = (state_q == i2cbp_pkg::ST_BITS) && (kind_q == i2cbp_pkg::K_RX) && step
                   && (ph_q == 2'h3) && (bit_q == i2cbp_pkg::ACK_SLOT);

  always_comb begin
    state_d   = state_q;
    kind_d    = kind_q;
    div_d     = tick ? '0 : div_q + 1'b1;
    ph_d      = ph_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    tx_d      = tx_q;
    rx_d      = rx_q;
    sel_d     = sel_q;
    rdata_d   = rdata_q;
    tx_pend_d = tx_pend_q;
    rx_full_d = rx_full_q;
    err_d     = err_q;
    stop_wr_d = stop_wr_q;
    stop_rd_d = stop_rd_q;
    ack_d     = ack_q;
    scl_oe_d  = scl_oe_q;
    sda_oe_d  = sda_oe_q;

    if (wr_en_in) begin
      unique case (addr_in)
        i2cbp_pkg::TX_OFS: begin
          tx_d      = wdata_in;
          tx_pend_d = 1'b1;
        end
        i2cbp_pkg::SEL_OFS: sel_d = wdata_in;
        i2cbp_pkg::CTL_OFS: begin
          stop_wr_d = wdata_in[i2cbp_pkg::CTL_STPWR_BIT];
          stop_rd_d = wdata_in[i2cbp_pkg::CTL_STPRD_BIT];
          if (!wdata_in[i2cbp_pkg::CTL_ERR_BIT]) begin
            err_d = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (rd_en_in) begin
      unique case (addr_in)
        i2cbp_pkg::RX_OFS: begin
          rdata_d   = rx_q;
          rx_full_d = 1'b0;
        end
        i2cbp_pkg::SEL_OFS: rdata_d = sel_q;
        i2cbp_pkg::CTL_OFS: begin
          rdata_d = 8'h00;
          rdata_d[i2cbp_pkg::CTL_RXF_BIT]   = rx_full_q;
          rdata_d[i2cbp_pkg::CTL_ERR_BIT]   = err_q;
          rdata_d[i2cbp_pkg::CTL_TXE_BIT]   = !tx_pend_q;
          rdata_d[i2cbp_pkg::CTL_STPRD_BIT] = stop_rd_q;
          rdata_d[i2cbp_pkg::CTL_STPWR_BIT] = stop_wr_q;
        end
        default: rdata_d = 8'h00;
      endcase
    end

    if (step && state_q != i2cbp_pkg::ST_IDLE && state_q != i2cbp_pkg::ST_HOLD) begin
      ph_d = ph_q + 2'h1;
    end

    unique case (state_q)
      i2cbp_pkg::ST_IDLE: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        if (tx_pend_q) begin
          state_d = i2cbp_pkg::ST_START;
          kind_d  = i2cbp_pkg::K_ADDR_WR;
          ph_d    = 2'h0;
          // slave select first, written as a write so the internal address can follow
          sh_d    = {sel_q[7:1], 1'b0};
        end
      end
      i2cbp_pkg::ST_START: begin
        if (step) begin
          scl_oe_d = (ph_q == 2'h3) || (ph_q == 2'h0);
          sda_oe_d = (ph_q >= 2'h2);
          if (ph_q == 2'h3) begin
            state_d = i2cbp_pkg::ST_BITS;
            bit_d   = 4'h0;
          end
        end
      end
      i2cbp_pkg::ST_BITS: begin
        if (step) begin
          unique case (ph_q)
            2'h0: begin
              scl_oe_d = 1'b1;
              if (bit_q == i2cbp_pkg::ACK_SLOT) begin
                sda_oe_d = sending ? 1'b0 : !stop_rd_q;
              end else begin
                sda_oe_d = sending ? !sh_q[7] : 1'b0;
              end
            end
            2'h1: scl_oe_d = 1'b0;
            2'h2: begin
              if (bit_q == i2cbp_pkg::ACK_SLOT) begin
                ack_d = !sda_s;
              end else if (!sending) begin
                sh_d = {sh_q[6:0], sda_s};
              end
            end
            2'h3: begin
              scl_oe_d = 1'b1;
              if (bit_q != i2cbp_pkg::ACK_SLOT) begin
                bit_d = bit_q + 4'h1;
                if (sending) begin
                  sh_d = {sh_q[6:0], 1'b0};
                end
              end else begin
                bit_d = 4'h0;
                if (sending && !ack_q) begin
                  // a refused byte is dropped so the bus goes idle
                  err_d     = 1'b1;
                  state_d   = i2cbp_pkg::ST_STOP;
                  tx_pend_d = tx_wr;
                end else begin
                  unique case (kind_q)
                    i2cbp_pkg::K_ADDR_WR: begin
                      kind_d    = i2cbp_pkg::K_TX;
                      sh_d      = tx_q;
                      tx_pend_d = tx_wr;
                    end
                    i2cbp_pkg::K_TX: begin
                      if (sel_q[0]) begin
                        // repeated start, now addressed for reading
                        state_d = i2cbp_pkg::ST_START;
                        kind_d  = i2cbp_pkg::K_ADDR_RD;
                        sh_d    = {sel_q[7:1], 1'b1};
                      end else if (stop_wr_q) begin
                        state_d = i2cbp_pkg::ST_STOP;
                      end else begin
                        state_d = i2cbp_pkg::ST_HOLD;
                      end
                    end
                    i2cbp_pkg::K_ADDR_RD: kind_d = i2cbp_pkg::K_RX;
                    i2cbp_pkg::K_RX: begin
                      rx_d      = sh_q;
                      rx_full_d = 1'b1;
                      state_d   = stop_rd_q ? i2cbp_pkg::ST_STOP : i2cbp_pkg::ST_HOLD;
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      i2cbp_pkg::ST_HOLD: begin
        scl_oe_d = 1'b1;
        sda_oe_d = 1'b0;
        ph_d     = 2'h0;
        if (kind_q == i2cbp_pkg::K_RX) begin
          if (!rx_full_q) begin
            state_d = i2cbp_pkg::ST_BITS;
          end
        end else if (tx_pend_q) begin
          state_d   = i2cbp_pkg::ST_BITS;
          sh_d      = tx_q;
          tx_pend_d = tx_wr;
        end else if (stop_wr_q) begin
          state_d = i2cbp_pkg::ST_STOP;
        end
      end
      i2cbp_pkg::ST_STOP: begin
        if (step) begin
          scl_oe_d = (ph_q == 2'h0);
          sda_oe_d = (ph_q <= 2'h1);
          if (ph_q == 2'h3) begin
            state_d   = i2cbp_pkg::ST_IDLE;
            stop_wr_d = 1'b0;
            stop_rd_d = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q   <= i2cbp_pkg::ST_IDLE;
      kind_q    <= i2cbp_pkg::K_ADDR_WR;
      div_q     <= '0;
      ph_q      <= 2'h0;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= i2cbp_pkg::TX_RST;
      rx_q      <= i2cbp_pkg::RX_RST;
      sel_q     <= i2cbp_pkg::SEL_RST;
      rdata_q   <= 8'h00;
      tx_pend_q <= 1'b0;
      rx_full_q <= 1'b0;
      err_q     <= 1'b0;
      stop_wr_q <= 1'b0;
      stop_rd_q <= 1'b0;
      ack_q     <= 1'b0;
      scl_oe_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      low_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      kind_q    <= kind_d;
      div_q     <= div_d;
      ph_q      <= ph_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      sel_q     <= sel_d;
      rdata_q   <= rdata_d;
      tx_pend_q <= tx_pend_d;
      rx_full_q <= rx_full_d;
      err_q     <= err_d;
      stop_wr_q <= stop_wr_d;
      stop_rd_q <= stop_rd_d;
      ack_q     <= ack_d;
      scl_oe_q  <= scl_oe_d;
      sda_oe_q  <= sda_oe_d;
      low_q     <= 1'b0;
    end
  end

  assign rdata_out  = rdata_q;
  assign scl_out    = low_q;
  assign sda_out    = low_q;
  assign scl_oe_out = scl_oe_q;
  assign sda_oe_out = sda_oe_q;

  addr_byte_load_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == i2cbp_pkg::ST_IDLE && tx_pend_q) |=> (sh_q == {$past(sel_q[7:1]), 1'b0})
  ) else $error("address byte not loaded from slave select");

  read_dir_bit_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == i2cbp_pkg::ST_BITS && kind_q == i2cbp_pkg::K_ADDR_RD && bit_q == 4'h0)
      |-> (sh_q[0] && sel_q[0])
  ) else $error("read address byte lacks direction bit");

  rx_overwrite_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rx_set |=> (rx_q == $past(sh_q))
  ) else $error("received byte not stored");

  rx_flag_set_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rx_set |=> rx_full_q
  ) else $error("receive flag not set on new byte");

  rx_flag_clr_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (rd_en_in && addr_in == i2cbp_pkg::RX_OFS && !rx_set) |=> !rx_full_q ##1 $stable(rx_q) [*1]
  ) else $error("receive flag not cleared by read");

  tx_write_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (wr_en_in && addr_in == i2cbp_pkg::TX_OFS) |=> (tx_pend_q && tx_q == $past(wdata_in))
  ) else $error("transmit byte not captured");

  sel_only_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == i2cbp_pkg::ST_BITS && kind_q == i2cbp_pkg::K_TX && bit_q == 4'h0 && ph_q == 2'h0)
      |-> (sh_q == tx_q || tx_pend_q)
  ) else $error("data byte does not come from transmit register");
endmodule

// [tb/i2cbp_slave.sv]
// behavioural two-wire target: acks its own address, logs written bytes, returns a counting read stream
module i2cbp_slave #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] rd_byte_in,
  output logic            sda_low_out,
  output logic      [7:0] byte_out,
  output int              n_bytes_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt   = -1;
  logic       act   = 0;
  logic       first = 0;
  logic       sel   = 0;
  logic       rd    = 0;
  logic [7:0] sh;
  logic [7:0] tx;
  initial begin
    sda_low_out = 0;
    byte_out = 8'h00;
    n_bytes_out = 0;
  end
  always @(negedge sda_in) if (scl_in) begin
    {act, first, sel, sda_low_out} = 4'b1100;
    cnt = -1;
  end
  always @(posedge sda_in) if (scl_in) begin
    act = 0;
    sda_low_out = 0;
  end
  always @(posedge scl_in) if (act) begin
    if (cnt < 8) sh = {sh[6:0], sda_in};
    else if (sel && rd && sda_in) sel = 0;
    else if (sel && rd) tx = tx + 8'h01;
  end
  always @(negedge scl_in) if (act) begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    sda_low_out = 0;
    if (cnt == 8 && (first || !rd)) begin
      // seven address bits first, then direction
      if (first) {sel, rd} = {sh[7:1] == ADDR, sh[0]};
      first = 0;
      // pre-decremented: the address ack bumps it to the first byte
      tx = rd_byte_in - 8'h01;
      if (sel) begin
        byte_out = sh;
        n_bytes_out++;
        sda_low_out = 1;
      end
    end
    if (cnt < 8 && sel && rd) sda_low_out = !tx[7-cnt];
  end
endmodule

// [tb/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADR = 7'h5a;
  logic        clk_in    = 0;
  logic        arst_n_in = 0;
  logic        wr_en_in  = 0;
  logic        rd_en_in  = 0;
  logic        rd_seen   = 0;
  logic [15:0] addr_in   = 16'h0000;
  logic [7:0]  wdata_in  = 8'h00;
  logic [7:0]  rd_data   = 8'h00;
  logic [7:0]  rdata_out, byte_out, v, mem, dat;
  logic        scl_out, scl_oe_out, sda_out, sda_oe_out, sda_low;
  logic [15:0] e;
  int          n_bytes;
  int          n_fail     = 0;
  int          n_compared = 0;
  logic [15:0] reg_q[$];
  logic [7:0]  bus_q[$];
  logic [15:0] ofs[5] = '{16'hffc0, 16'hffc1, 16'hffc2, 16'hffc3, 16'hffc4};
  wire         scl = !scl_oe_out;
  wire         sda = !(sda_oe_out || sda_low);

  always #20 clk_in = !clk_in;

  i2cbp_master uut (.clk_in, .arst_n_in, .addr_in, .wr_en_in, .rd_en_in, .wdata_in, .rdata_out,
    .scl_in(scl), .scl_out, .scl_oe_out, .sda_in(sda), .sda_out, .sda_oe_out);
  i2cbp_slave #(.ADDR(ADR)) peer (.scl_in(scl), .sda_in(sda), .rd_byte_in(rd_data),
    .sda_low_out(sda_low), .byte_out, .n_bytes_out(n_bytes));

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk_in) #2;
    {wr_en_in, addr_in, wdata_in} = {1'b1, a, d};
    @(posedge clk_in) #2;
    wr_en_in = 0;
  endtask

  // a zero mask marks a poll: nothing is compared
  task automatic rd(logic [15:0] a, logic [7:0] x, logic [7:0] m = 8'hff);
    @(posedge clk_in) #2;
    {rd_en_in, addr_in} = {1'b1, a};
    reg_q.push_back({m, x});
    @(posedge clk_in) #2;
    rd_en_in = 0;
    v = rdata_out;
  endtask

  task automatic wait_bytes(int n);
    for (int i = 0; i < 9000 && n_bytes < n; i++) @(posedge clk_in);
    if (n_bytes < n) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic poll(logic [7:0] m, logic [7:0] want);
    for (int i = 0; i < 6000; i++) begin
      rd(16'hffc0, 8'h00, 8'h00);
      if ((v & m) == want) return;
    end
    n_fail++;
    complete_run();
  endtask

  always @(posedge clk_in) begin
    if (rd_seen) begin
      e = reg_q.pop_front();
      if (e[15:8] != 8'h00) check("rdata", rdata_out & e[15:8], e[7:0] & e[15:8]);
    end
    rd_seen <= rd_en_in;
  end

  always @(n_bytes) if (n_bytes > 0) #1 check("target byte", byte_out, bus_q.pop_front());

  initial begin
    void'($urandom(32'hc783553e));
    {mem, dat, rd_data} = 24'($urandom);
    repeat (6) @(posedge clk_in);
    #2 arst_n_in = 1;
    wr(16'hffc4, 8'hff);
    // status shows the transmit register empty after reset
    foreach (ofs[i]) rd(ofs[i], (i == 0) ? 8'h08 : 8'h00);
    wr(16'hffc3, {ADR, 1'b0});
    rd(16'hffc3, {ADR, 1'b0});
    bus_q = '{{ADR, 1'b0}, mem, dat};
    wr(16'hffc1, mem);
    wait_bytes(2);
    wr(16'hffc1, dat);
    wait_bytes(3);
    wr(16'hffc0, 8'h01);
    poll(8'h01, 8'h00);
    rd(16'hffc0, 8'h00, 8'h80);
    bus_q = '{{ADR, 1'b0}, mem, {ADR, 1'b1}};
    wr(16'hffc3, {ADR, 1'b1});
    wr(16'hffc1, mem);
    poll(8'h80, 8'h80);
    wr(16'hffc0, 8'h02);
    rd(16'hffc2, rd_data);
    rd(16'hffc0, 8'h00, 8'h80);
    poll(8'h80, 8'h80);
    rd(16'hffc2, rd_data + 8'h01);
    poll(8'h02, 8'h00);
    // another target's address draws no ack, so the error flag rises
    wr(16'hffc3, {~ADR, 1'b0});
    wr(16'hffc1, mem);
    poll(8'h20, 8'h20);
    wr(16'hffc0, 8'h00);
    rd(16'hffc0, 8'h08, 8'h28);
    check("line drive", {6'h00, scl_out, sda_out}, 8'h00);
    complete_run();
  end
endmodule
